// [flash_link_if.sv]
// link between the rewrite controller and the flash sequencer
`timescale 1ns/1ps
interface flash_link_if #(parameter int BLOCK_W = 8);
  import flash_rw_pkg::*;
  logic               cmd_start;
  op_t                cmd_op;
  area_t              cmd_area;
  logic [BLOCK_W-1:0] cmd_block;
  mode_t              rw_mode;
  logic               suspend_allowed;
  logic               irq_suspend_enable;
  logic               esr_set;
  logic               esr_clr;
  logic               irq_mask_req;
  logic               irq_soft_req;
  logic               irq_nmi_req;
  logic               acc_req;
  logic [BLOCK_W-1:0] acc_block;
  logic               busy;
  logic               suspended;
  logic               erase_suspend_request;
  logic               irq_grant;
  logic               nmi_grant;
  logic               op_done;
  logic               op_aborted;
  logic               flash_reset;
  logic               acc_ok;
  logic               acc_refused;

  modport dev (
    input  cmd_start, cmd_op, cmd_area, cmd_block, rw_mode, suspend_allowed,
    input  irq_suspend_enable, esr_set, esr_clr, irq_mask_req, irq_soft_req,
    input  irq_nmi_req, acc_req, acc_block,
    output busy, suspended, erase_suspend_request, irq_grant, nmi_grant,
    output op_done, op_aborted, flash_reset, acc_ok, acc_refused
  );
  modport ctl (
    output cmd_start, cmd_op, cmd_area, cmd_block, rw_mode, suspend_allowed,
    output irq_suspend_enable, esr_set, esr_clr, irq_mask_req, irq_soft_req,
    output irq_nmi_req, acc_req, acc_block,
    input  busy, suspended, erase_suspend_request, irq_grant, nmi_grant,
    input  op_done, op_aborted, flash_reset, acc_ok, acc_refused
  );
endinterface : flash_link_if

// [flash_link_monitor.sv]
// assertion checker watching the link between controller and sequencer
`timescale 1ns/1ps
module flash_link_monitor
  import flash_rw_pkg::*;
(
  input wire logic  clock,
  input wire logic  rst,
  input wire logic  busy,
  input wire logic  suspended,
  input wire logic  erase_suspend_request,
  input wire logic  irq_grant,
  input wire logic  op_aborted,
  input wire logic  flash_reset,
  input wire logic  irq_mask_req,
  input wire logic  irq_soft_req,
  input wire logic  irq_nmi_req,
  input wire op_t   cmd_op,
  input wire area_t cmd_area,
  input wire mode_t rw_mode,
  input wire logic  suspend_allowed,
  input wire logic  irq_suspend_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================================
  // suspend and resume
  property p_auto_sus; irq_mask_req && busy && !suspended && cmd_op == OP_ERASE
    && suspend_allowed && irq_suspend_enable
    && (cmd_area == AREA_DATA || rw_mode == rewrite_mode_rom_exec) |=> erase_suspend_request;
  endproperty
  a_auto_sus: assert property (p_auto_sus) else $error("no auto suspend");
  property p_lat; $rose(erase_suspend_request) |-> !suspended[*8] ##[1:5] suspended; endproperty
  a_lat: assert property (p_lat) else $error("suspend latency wrong");
  property p_resume; $fell(erase_suspend_request) && suspended |-> ##[1:3] !suspended; endproperty
  a_resume: assert property (p_resume) else $error("erase not resumed");
  property p_soft; irq_soft_req && !erase_suspend_request |=> !erase_suspend_request; endproperty
  a_soft: assert property (p_soft) else $error("soft irq suspended");
  // ==========================================================================
  // interrupt policy
  property p_run; irq_mask_req && busy && cmd_area == AREA_DATA && !(cmd_op == OP_ERASE
    && suspend_allowed && irq_suspend_enable) |=> irq_grant && !suspended; endproperty
  a_run: assert property (p_run) else $error("irq not served");
  property p_rom_sus; irq_mask_req && busy && rw_mode == rewrite_mode_rom_exec
    && cmd_area == AREA_PROM && cmd_op == OP_ERASE && suspend_allowed && irq_suspend_enable
    |-> ##1 !irq_grant[*8]; endproperty
  a_rom_sus: assert property (p_rom_sus) else $error("handler before suspend");
  property p_hold; irq_mask_req && busy && !suspended && rw_mode == rewrite_mode_rom_exec
    && cmd_area == AREA_PROM && !irq_suspend_enable |=> !irq_grant[*3]; endproperty
  a_hold: assert property (p_hold) else $error("irq not held");
  property p_abort; irq_nmi_req && busy && !flash_reset && rw_mode == rewrite_mode_ram_exec
    && cmd_area == AREA_PROM |=> op_aborted ##1 flash_reset; endproperty
  a_abort: assert property (p_abort) else $error("no forced abort");
  c_susp: cover property ($rose(suspended));
  c_abort: cover property (op_aborted);
  c_grant: cover property (irq_grant);
endmodule : flash_link_monitor

// [flash_rewrite_ctrl.sv]
// cpu-side rewrite controller: avalon-mm registers driving the flash link
`timescale 1ns/1ps
`include "flash_rw_cfg.svh"

module flash_rewrite_ctrl
  import flash_rw_pkg::*;
#(
  parameter int BLOCK_W = `BLOCK_W_DEFAULT
) (
  input  wire logic                avs_clock_unused_n,
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic [`ADDR_W-1:0]  avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  flash_link_if.ctl                lnk
);

  initial begin
    if (BLOCK_W < 1 || BLOCK_W > 16)
      $error("flash_rewrite_ctrl: BLOCK_W must be 1 to 16");
  end

  // ===========================================================================
  // avalon slave: one wait cycle, then the access completes
  // ===========================================================================
  logic [31:0]       cfg_q;
  logic [`FLG_W-1:0] flag_q;
  logic [31:0]       rdata_q;
  logic              wait_q;
  logic              wr_go;
  logic              rd_go;
  logic [31:0]       pulse_q;
  logic              vec_ram;
  logic              ram_prom;
  logic              blk0_erase;

  assign wr_go = avs_write && !wait_q;
  assign rd_go = avs_read && !wait_q;

  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  always_ff @(posedge clock) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      wait_q <= 1'b1;
      if ((avs_read || avs_write) && wait_q) begin
        wait_q <= 1'b0;
        if (hit(avs_address, `ADDR_CFG))
          rdata_q <= cfg_q;
        else if (hit(avs_address, `ADDR_SUSP))
          rdata_q <= {31'h0, lnk.erase_suspend_request};
        else if (hit(avs_address, `ADDR_STAT))
          rdata_q <= {26'h0, lnk.flash_reset, ram_prom, lnk.suspended,
                      lnk.erase_suspend_request, lnk.busy, 1'b0};
        else if (hit(avs_address, `ADDR_FLAG))
          rdata_q <= {24'h0, flag_q};
        else
          rdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst)
      cfg_q <= `CFG_RESET;
    else if (ce && wr_go && hit(avs_address, `ADDR_CFG))
      cfg_q <= avs_writedata;
  end

  // ===========================================================================
  // link requests, one-cycle pulses from register writes
  // ===========================================================================
  assign vec_ram    = cfg_q[`CFG_VEC_RAM];
  assign ram_prom   = lnk.busy && cfg_q[`CFG_AREA] &&
                      (cfg_q[`CFG_MODE] == rewrite_mode_ram_exec);
  assign blk0_erase = lnk.busy && (cfg_q[`CFG_OP] == OP_ERASE) &&
                      (cfg_q[`CFG_BLK_LSB +: BLOCK_W] == '0);

  logic evt_mask_ok;
  logic evt_nmi_ok;
  logic evt_trap_ok;
  assign evt_mask_ok = !ram_prom || vec_ram;
  assign evt_nmi_ok  = !blk0_erase;
  assign evt_trap_ok = !ram_prom;

  // bit order: start, esr set, esr clear, mask, soft, nmi, access
  always_ff @(posedge clock) begin
    if (rst) begin
      pulse_q <= 32'h0000_0000;
    end else if (ce) begin
      pulse_q <= 32'h0000_0000;
      if (wr_go && hit(avs_address, `ADDR_CMD))
        pulse_q[0] <= avs_writedata[0] && !lnk.busy;
      if (wr_go && hit(avs_address, `ADDR_SUSP)) begin
        pulse_q[1] <= avs_writedata[0];
        pulse_q[2] <= !avs_writedata[0];
      end
      if (wr_go && hit(avs_address, `ADDR_EVT)) begin
        pulse_q[3] <= avs_writedata[`EVT_MASK] && evt_mask_ok;
        pulse_q[4] <= avs_writedata[`EVT_SOFT] && evt_mask_ok;
        pulse_q[5] <= avs_writedata[`EVT_NMI] && evt_nmi_ok;
      end
      if (wr_go && hit(avs_address, `ADDR_ACC))
        pulse_q[6] <= 1'b1;
    end
  end

  logic [BLOCK_W-1:0] acc_blk_q;
  always_ff @(posedge clock) begin
    if (rst)
      acc_blk_q <= '0;
    else if (ce && wr_go && hit(avs_address, `ADDR_ACC))
      acc_blk_q <= avs_writedata[BLOCK_W-1:0];
  end

  // ===========================================================================
  // sticky flags, write one to clear, a new event wins
  // ===========================================================================
  logic [`FLG_W-1:0] ev;
  logic              evt_refused;
  assign evt_refused = wr_go && hit(avs_address, `ADDR_EVT) &&
                       ((avs_writedata[`EVT_MASK] && !evt_mask_ok) ||
                        (avs_writedata[`EVT_SOFT] && !evt_mask_ok) ||
                        (avs_writedata[`EVT_NMI] && !evt_nmi_ok) ||
                        (avs_writedata[`EVT_TRAP] && !evt_trap_ok));
  assign ev = {lnk.op_aborted, evt_refused, lnk.acc_refused, lnk.acc_ok,
               lnk.op_aborted, lnk.op_done, lnk.nmi_grant, lnk.irq_grant};

  logic reerase_clr;
  assign reerase_clr = lnk.op_done && (cfg_q[`CFG_OP] == OP_ERASE);

  always_ff @(posedge clock) begin
    if (rst) begin
      flag_q <= '0;
    end else if (ce) begin
      for (int i = 0; i < `FLG_W; i++) begin
        if (ev[i])
          flag_q[i] <= 1'b1;
        else if (wr_go && hit(avs_address, `ADDR_FLAG) && avs_writedata[i])
          flag_q[i] <= 1'b0;
        else if (i == `FLG_REERASE && reerase_clr)
          flag_q[i] <= 1'b0;
      end
    end
  end

  assign avs_readdata           = rdata_q;
  assign avs_waitrequest        = wait_q;
  assign lnk.cmd_start          = pulse_q[0];
  assign lnk.cmd_op             = op_t'(cfg_q[`CFG_OP]);
  assign lnk.cmd_area           = area_t'(cfg_q[`CFG_AREA]);
  assign lnk.cmd_block          = cfg_q[`CFG_BLK_LSB +: BLOCK_W];
  assign lnk.rw_mode            = mode_t'(cfg_q[`CFG_MODE]);
  assign lnk.suspend_allowed    = cfg_q[`CFG_SUS_OK];
  assign lnk.irq_suspend_enable = cfg_q[`CFG_IRQ_SUS];
  assign lnk.esr_set            = pulse_q[1];
  assign lnk.esr_clr            = pulse_q[2];
  assign lnk.irq_mask_req       = pulse_q[3];
  assign lnk.irq_soft_req       = pulse_q[4];
  assign lnk.irq_nmi_req        = pulse_q[5];
  assign lnk.acc_req            = pulse_q[6];
  assign lnk.acc_block          = acc_blk_q;

endmodule : flash_rewrite_ctrl

// [flash_rewrite_interrupt_suspend_bench.sv]
// self-checking bench for the controller and sequencer pair
`timescale 1ns/1ps
`include "flash_rw_cfg.svh"
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", n, e, v); end end
module flash_rewrite_interrupt_suspend_bench;
  import flash_rw_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [4:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] rd;
  int          bad_count = 0;
  int          total_checks = 0;
  // config, event, status twenty cycles later, flags at the end
  localparam logic [11:0] CFG_ROW [8] = '{12'h118, 12'h118, 12'h110, 12'h119, 12'h11e,
    12'h10e, 12'h122, 12'h000};
  localparam logic [3:0] EVT_ROW [8] = '{4'h1, 4'h2, 4'h1, 4'h1, 4'h1, 4'h1, 4'h4, 4'h4};
  localparam logic [5:0] ST_ROW [8] = '{6'h0e, 6'h02, 6'h02, 6'h02, 6'h0e, 6'h02, 6'h00, 6'h02};
  localparam logic [7:0] FL_ROW [8] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h8a, 8'h44};
  always #25 clock = ~clock;
  flash_link_if lnk ();
  flash_rewrite_seq #(.ERASE_CYC(60), .PROGRAM_CYC(40), .RESTART_CYC(5)) u_flash_rewrite_seq (
    .clock(clock), .rst(rst), .ce(ce), .lnk(lnk));
  flash_rewrite_ctrl u_flash_rewrite_ctrl (.avs_clock_unused_n(1'b0), .clock(clock), .rst(rst),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lnk(lnk));
  flash_link_monitor u_flash_link_monitor (.clock(clock), .rst(rst), .busy(lnk.busy),
    .suspended(lnk.suspended), .erase_suspend_request(lnk.erase_suspend_request),
    .irq_grant(lnk.irq_grant), .op_aborted(lnk.op_aborted), .flash_reset(lnk.flash_reset),
    .irq_mask_req(lnk.irq_mask_req), .irq_soft_req(lnk.irq_soft_req),
    .irq_nmi_req(lnk.irq_nmi_req), .cmd_op(lnk.cmd_op), .cmd_area(lnk.cmd_area),
    .rw_mode(lnk.rw_mode), .suspend_allowed(lnk.suspend_allowed),
    .irq_suspend_enable(lnk.irq_suspend_enable));
  // ==========================================================================
  // bus access and completion
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic finish_op;
    repeat (60) begin
      bus(1'b0, `ADDR_STAT, '0);
      if (rd[1] === 1'b0) break;
    end
    bus(1'b0, `ADDR_FLAG, '0);
  endtask : finish_op
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // sequence
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `ADDR_CFG, 32'(CFG_ROW[i]));
      bus(1'b1, `ADDR_CMD, 32'h1);
      bus(1'b1, `ADDR_EVT, 32'(EVT_ROW[i]));
      repeat (20) @(posedge clock);
      bus(1'b0, `ADDR_STAT, '0);
      `CHK("status", ST_ROW[i], rd[5:0] & 6'h3e)
      bus(1'b1, `ADDR_SUSP, '0);
      finish_op();
      `CHK("flags", FL_ROW[i], rd[7:0])
      bus(1'b1, `ADDR_FLAG, 32'hff);
    end
    bus(1'b1, `ADDR_CFG, 32'h108);
    bus(1'b1, `ADDR_CMD, 32'h1);
    bus(1'b1, `ADDR_SUSP, 32'h1);
    repeat (20) @(posedge clock);
    bus(1'b0, `ADDR_STAT, '0);
    `CHK("manual suspend", 6'h0e, rd[5:0] & 6'h3e)
    bus(1'b1, `ADDR_ACC, 32'h1);
    bus(1'b1, `ADDR_ACC, 32'h2);
    // the access answer reaches the flag register one edge later
    @(posedge clock);
    bus(1'b0, `ADDR_FLAG, '0);
    `CHK("access", 8'h30, rd[7:0])
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, `ADDR_CFG, '0);
    `CHK("config after reset", 32'h0, rd)
    bus(1'b0, 5'h1c, '0);
    `CHK("unmapped", 32'h0, rd)
    // ram-exec program ROM erase frozen by the clock enable, then gated events
    bus(1'b1, `ADDR_CFG, 32'h102);
    bus(1'b1, `ADDR_CMD, 32'h1);
    ce <= 1'b0;
    repeat (100) @(posedge clock);
    ce <= 1'b1;
    bus(1'b0, `ADDR_STAT, '0);
    `CHK("frozen status", 6'h12, rd[5:0] & 6'h3e)
    bus(1'b1, `ADDR_EVT, 32'h9);
    finish_op();
    `CHK("gated events", 8'h44, rd[7:0])
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    give_verdict();
  end
endmodule : flash_rewrite_interrupt_suspend_bench

// [flash_rewrite_seq.sv]
// flash rewrite sequencer with interrupt-driven erase suspend and forced abort
`timescale 1ns/1ps
`include "flash_rw_cfg.svh"

module flash_rewrite_seq
  import flash_rw_pkg::*;
#(
  parameter int BLOCK_W     = `BLOCK_W_DEFAULT,
  parameter int ERASE_CYC   = `ERASE_CYC_DEFAULT,
  parameter int PROGRAM_CYC = `PROGRAM_CYC_DEFAULT,
  parameter int RESTART_CYC = `RESTART_CYC_DEFAULT
) (
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  ce,
  flash_link_if.dev  lnk
);

  localparam int          SUSP_CYC = `SUSPEND_LATENCY_CYC;
  localparam logic [31:0] ERASE_N  = 32'(ERASE_CYC);
  localparam logic [31:0] PROG_N   = 32'(PROGRAM_CYC);
  localparam logic [31:0] RST_N    = 32'(RESTART_CYC);
  localparam logic [31:0] SUSP_N   = 32'(SUSP_CYC);

  initial begin
    if (ERASE_CYC < 1 || PROGRAM_CYC < 1 || RESTART_CYC < 1 || SUSP_CYC < 1)
      $error("flash_rewrite_seq: every cycle count must be at least one");
    if (BLOCK_W < 1 || BLOCK_W > 16)
      $error("flash_rewrite_seq: BLOCK_W must be 1 to 16");
  end

  // ===========================================================================
  // operation context
  // ===========================================================================
  seq_state_t         state_q, state_d;
  logic [31:0]        cnt_q;
  logic [31:0]        lat_q;
  area_t              area_q;
  mode_t              mode_q;
  logic [BLOCK_W-1:0] blk_q;
  logic               esr_q;
  logic               pend_q;
  logic               busy_q;
  logic               susp_q;
  logic               irq_grant_q;
  logic               nmi_grant_q;
  logic               done_q;
  logic               abort_q;
  logic               freset_q;
  logic               acc_ok_q;
  logic               acc_no_q;
  logic               nmi_wait_q;

  function automatic logic op_running(input seq_state_t s);
    op_running = (s == ST_ERASE) || (s == ST_SUSP_WAIT) ||
                 (s == ST_SUSPENDED) || (s == ST_PROGRAM);
  endfunction : op_running

  function automatic logic erasing(input seq_state_t s);
    erasing = (s == ST_ERASE) || (s == ST_SUSP_WAIT);
  endfunction : erasing

  logic prom_busy;
  logic susp_ok;
  logic auto_susp;
  logic hold_irq;
  logic abort_now;
  logic any_irq;
  logic last_cnt;

  // policy is chosen by the captured mode and area
  assign prom_busy = op_running(state_q) && (area_q == AREA_PROM);
  assign susp_ok   = lnk.suspend_allowed && lnk.irq_suspend_enable;
  assign any_irq   = lnk.irq_mask_req || lnk.irq_soft_req;
  // only a hardware maskable request arms the automatic suspend
  assign auto_susp = lnk.irq_mask_req && erasing(state_q) && susp_ok &&
                     ((area_q == AREA_DATA) ||
                      (mode_q == rewrite_mode_rom_exec));
  // rom-exec program ROM: handler waits for suspension or completion
  assign hold_irq  = prom_busy && (mode_q == rewrite_mode_rom_exec) &&
                     (state_q != ST_SUSPENDED);
  assign abort_now = lnk.irq_nmi_req && prom_busy &&
                     (mode_q == rewrite_mode_ram_exec);
  assign last_cnt  = (cnt_q == 32'h0000_0001);

  // ===========================================================================
  // state machine
  // ===========================================================================
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (lnk.cmd_start)
          state_d = (lnk.cmd_op == OP_ERASE) ? ST_ERASE : ST_PROGRAM;
      end
      ST_ERASE: begin
        if (last_cnt)
          state_d = ST_IDLE;
        else if (esr_q)
          state_d = ST_SUSP_WAIT;
      end
      ST_SUSP_WAIT: begin
        if (!esr_q)
          state_d = ST_ERASE;
        else if (lat_q == 32'h0000_0001)
          state_d = ST_SUSPENDED;
      end
      ST_SUSPENDED: begin
        if (!esr_q)
          state_d = ST_ERASE;
      end
      ST_PROGRAM: begin
        // suspend requests do not touch programming
        if (last_cnt)
          state_d = ST_IDLE;
      end
      ST_RESTART: begin
        if (cnt_q == 32'h0000_0001)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    if (abort_now)
      state_d = ST_RESTART;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
      susp_q  <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      busy_q  <= (state_d != ST_IDLE);
      susp_q  <= (state_d == ST_SUSPENDED);
    end
  end

  // ===========================================================================
  // operation and latency counters
  // ===========================================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      if (abort_now)
        cnt_q <= RST_N;
      else if (state_q == ST_IDLE && lnk.cmd_start)
        cnt_q <= (lnk.cmd_op == OP_ERASE) ? ERASE_N : PROG_N;
      else if (state_q == ST_ERASE || state_q == ST_PROGRAM ||
               state_q == ST_RESTART)
        cnt_q <= cnt_q - 32'h0000_0001;
    end
  end

  // erase progress holds while the suspend latency runs out
  always_ff @(posedge clock) begin
    if (rst) begin
      lat_q <= 32'h0000_0000;
    end else if (ce) begin
      if (state_q == ST_ERASE && esr_q)
        lat_q <= SUSP_N;
      else if (state_q == ST_SUSP_WAIT)
        lat_q <= lat_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      area_q <= AREA_DATA;
      mode_q <= rewrite_mode_ram_exec;
      blk_q  <= '0;
    end else if (ce && state_q == ST_IDLE && lnk.cmd_start) begin
      area_q <= lnk.cmd_area;
      mode_q <= lnk.rw_mode;
      blk_q  <= lnk.cmd_block;
    end
  end

  // ===========================================================================
  // erase-suspend request bit
  // ===========================================================================
  // a set, from hardware or from the handler, wins over a clear
  always_ff @(posedge clock) begin
    if (rst) begin
      esr_q <= 1'b0;
    end else if (ce) begin
      if (abort_now || state_d == ST_IDLE)
        esr_q <= 1'b0;
      else if (auto_susp || (lnk.esr_set && erasing(state_q)))
        esr_q <= 1'b1;
      else if (lnk.esr_clr)
        esr_q <= 1'b0;
    end
  end

  // ===========================================================================
  // interrupt grants
  // ===========================================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      pend_q      <= 1'b0;
      irq_grant_q <= 1'b0;
    end else if (ce) begin
      irq_grant_q <= 1'b0;
      if (any_irq && !hold_irq && !pend_q) begin
        irq_grant_q <= 1'b1;
      end else if (any_irq || pend_q) begin
        if (!hold_irq || abort_now) begin
          pend_q      <= 1'b0;
          irq_grant_q <= 1'b1;
        end else begin
          pend_q <= 1'b1;
        end
      end
    end
  end

  // watchdog-class requests are granted at once, except in restart or when they abort a ram-exec program ROM command
  always_ff @(posedge clock) begin
    if (rst) begin
      nmi_wait_q  <= 1'b0;
      nmi_grant_q <= 1'b0;
      abort_q     <= 1'b0;
      freset_q    <= 1'b0;
    end else if (ce) begin
      nmi_grant_q <= 1'b0;
      abort_q     <= abort_now;
      if (abort_now) begin
        nmi_wait_q <= 1'b1;
        freset_q   <= 1'b1;
      end else if (state_q == ST_RESTART && state_d == ST_IDLE) begin
        nmi_wait_q  <= 1'b0;
        freset_q    <= 1'b0;
        nmi_grant_q <= nmi_wait_q || lnk.irq_nmi_req;
      end else if (lnk.irq_nmi_req && state_q != ST_RESTART) begin
        nmi_grant_q <= 1'b1;
      end else if (lnk.irq_nmi_req) begin
        nmi_wait_q <= 1'b1;
      end
    end
  end

  // ===========================================================================
  // completion and block access
  // ===========================================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= (state_q == ST_ERASE || state_q == ST_PROGRAM) && last_cnt &&
                !abort_now;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_ok_q <= 1'b0;
      acc_no_q <= 1'b0;
    end else if (ce) begin
      acc_ok_q <= 1'b0;
      acc_no_q <= 1'b0;
      if (lnk.acc_req) begin
        if (state_q == ST_IDLE ||
            (state_q == ST_SUSPENDED && lnk.acc_block != blk_q))
          acc_ok_q <= 1'b1;
        else
          acc_no_q <= 1'b1;
      end
    end
  end

  assign lnk.busy                  = busy_q;
  assign lnk.suspended             = susp_q;
  assign lnk.erase_suspend_request = esr_q;
  assign lnk.irq_grant             = irq_grant_q;
  assign lnk.nmi_grant             = nmi_grant_q;
  assign lnk.op_done               = done_q;
  assign lnk.op_aborted            = abort_q;
  assign lnk.flash_reset           = freset_q;
  assign lnk.acc_ok                = acc_ok_q;
  assign lnk.acc_refused           = acc_no_q;

endmodule : flash_rewrite_seq

// [flash_rw_cfg.svh]
// timing counts, link widths and controller register map for the flash rewrite pair
`ifndef FLASH_RW_CFG_SVH
`define FLASH_RW_CFG_SVH

`define CLK_PERIOD_NS        50
`define SUSPEND_LATENCY_NS   500
`define SUSPEND_LATENCY_CYC  ((`SUSPEND_LATENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYC_DEFAULT    20000
`define PROGRAM_CYC_DEFAULT  1000
`define RESTART_CYC_DEFAULT  100
`define BLOCK_W_DEFAULT      8

`define REG_CFG      4'h0
`define REG_CMD      4'h4
`define REG_SUSP     4'h8
`define REG_EVT      4'hc
`define REG_ACC      4'h0
`define REG_STAT     4'h4
`define REG_FLAG     4'h8
`define ADDR_W       5
`define ADDR_CFG     5'h00
`define ADDR_CMD     5'h04
`define ADDR_SUSP    5'h08
`define ADDR_EVT     5'h0c
`define ADDR_ACC     5'h10
`define ADDR_STAT    5'h14
`define ADDR_FLAG    5'h18

`define CFG_OP       0
`define CFG_AREA     1
`define CFG_MODE     2
`define CFG_SUS_OK   3
`define CFG_IRQ_SUS  4
`define CFG_VEC_RAM  5
`define CFG_BLK_LSB  8
`define CFG_RESET    32'h0000_0000

`define EVT_MASK     0
`define EVT_SOFT     1
`define EVT_NMI      2
`define EVT_TRAP     3

`define FLG_IRQ      0
`define FLG_NMI      1
`define FLG_DONE     2
`define FLG_ABORT    3
`define FLG_ACC_OK   4
`define FLG_ACC_NO   5
`define FLG_EVT_NO   6
`define FLG_REERASE  7
`define FLG_W        8

`endif

// [flash_rw_pkg.sv]
// types shared by the flash rewrite sequencer and its controller
package flash_rw_pkg;
  typedef enum logic [0:0] {OP_ERASE = 1'b0, OP_PROGRAM = 1'b1} op_t;
  typedef enum logic [0:0] {AREA_DATA = 1'b0, AREA_PROM = 1'b1} area_t;
  typedef enum logic [0:0] {
    rewrite_mode_ram_exec = 1'b0,
    rewrite_mode_rom_exec = 1'b1
  } mode_t;
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ERASE     = 3'b001,
    ST_SUSP_WAIT = 3'b010,
    ST_SUSPENDED = 3'b011,
    ST_PROGRAM   = 3'b100,
    ST_RESTART   = 3'b101
  } seq_state_t;
endpackage : flash_rw_pkg
